// *** rtl/fwp_top.sv ***
// Feedback word processor: link feedback paths and parallel port.
// Assumes link and parallel pins are asynchronous, sequencer is local.
`timescale 1ns/100ps
`default_nettype none
`include "fwp_map.svh"
module fwp_top (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [15:0] link_word_i,
  input wire logic link_stb_i,
  input wire logic [31:0] dio_in_i,
  output logic [31:0] dio_out_o,
  output logic [31:0] dio_oe_n_o,
  input wire logic fb_req_i,
  input wire fwp_pkg::fwp_src_t fb_src_i,
  input wire logic fb_exec_i,
  output logic fb_ack_o,
  output logic [16:0] fb_data_o,
  input wire logic par_wait_i,
  output logic par_trig_o,
  input wire logic par_play_i,
  output logic ent_stb_o,
  output logic [9:0] ent_idx_o,
  output logic cfg_busy_o
);
  import fwp_pkg::*;

  // All state of the block
  typedef struct packed {
    logic [16:0] lnk1;
    logic [16:0] lnk2;
    logic stb_d;
    logic [15:0] word;
    logic [31:0] dio1;
    logic [31:0] dio2;
    logic vld_d;
    fwp_par_t [1:0] par;
    fwp_par_t pend;
    logic pend_path;
    fwp_cfg_st_t cst;
    logic [5:0] cnt;
    logic busy;
    logic [4:0] vidx;
    logic vpol;
    logic [4:0] dsh;
    logic [31:0] dmask;
    logic [31:0] dout;
    logic [31:0] oen;
    logic wait_arm;
    logic trig;
    logic play_pend;
    logic [31:0] rdata;
    logic ack;
    logic [16:0] fbd;
    logic ent;
    logic [9:0] idx;
    logic [9:0] last_idx;
  } fwp_st_t;

  fwp_st_t r_reg;
  fwp_st_t r_next;
  logic [1:0][16:0] res;
  logic [1:0][9:0] pidx;
  logic qual;
  logic [9:0] dio_idx;
  fwp_src_t cmd_src;
  logic cmd_ok;

  // Selector to path: A and its alias to 0, B and its alias to 1
  function automatic logic path_b(input fwp_src_t s);
    path_b = (s == SRC_B) || (s == SRC_LEG_DEC);
  endfunction : path_b

  // Selector names a processed path
  function automatic logic is_proc(input fwp_src_t s);
    is_proc = (s == SRC_A) || (s == SRC_B) || (s == SRC_LEG_REG) || (s == SRC_LEG_DEC);
  endfunction : is_proc

  // Two identical processed paths on the held word
  fwp_path_if pif[2] ();
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_path
      assign pif[g].par = r_reg.par[g];
      assign pif[g].word = r_reg.word;
      assign res[g] = pif[g].result;
      assign pidx[g] = pif[g].index;
      fwp_proc u_proc (
        .p(pif[g])
      );
    end
  endgenerate

  // Valid qualifier and parallel index from the synchronised port
  assign qual = (r_reg.dio2[r_reg.vidx] == r_reg.vpol);
  assign dio_idx = 10'((r_reg.dio2 >> r_reg.dsh) & r_reg.dmask);
  assign cmd_src = fwp_src_t'(reg_wdata_i[`FWP_PATH_LSB +: 3]);
  assign cmd_ok = is_proc(cmd_src)
               && (reg_wdata_i[`FWP_LEN_LSB +: 5] >= `FWP_LEN_MIN)
               && (reg_wdata_i[`FWP_LEN_LSB +: 5] <= `FWP_LEN_MAX);

  // Next state of the whole block
  always_comb begin
    r_next = r_reg;
    r_next.lnk1 = {link_stb_i, link_word_i};
    r_next.lnk2 = r_reg.lnk1;
    r_next.stb_d = r_reg.lnk2[16];
    if (r_reg.lnk2[16] && !r_reg.stb_d) begin
      r_next.word = r_reg.lnk2[15:0];
    end
    r_next.dio1 = dio_in_i;
    r_next.dio2 = r_reg.dio1;
    r_next.vld_d = qual;
    r_next.ack = 1'b0;
    r_next.ent = 1'b0;
    r_next.trig = 1'b0;
    r_next.rdata = '0;
    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `FWP_A_CFG: begin
          if (r_reg.cst == CS_IDLE && cmd_ok) begin
            r_next.pend.shift = reg_wdata_i[`FWP_SH_LSB +: 4];
            r_next.pend.length = reg_wdata_i[`FWP_LEN_LSB +: 5];
            r_next.pend.offset = reg_wdata_i[`FWP_OFS_LSB +: 10];
            r_next.pend.done = 1'b1;
            r_next.pend_path = path_b(cmd_src);
            r_next.cst = CS_BUSY;
            r_next.cnt = `FWP_CFG_CYC - 6'h01;
          end
        end
        `FWP_A_DIO_CFG: begin
          r_next.vidx = reg_wdata_i[`FWP_VIDX_LSB +: 5];
          r_next.vpol = reg_wdata_i[`FWP_VPOL_BIT];
          r_next.dsh = reg_wdata_i[`FWP_DSH_LSB +: 5];
        end
        `FWP_A_DIO_MASK: r_next.dmask = reg_wdata_i;
        `FWP_A_DIO_OUT: r_next.dout = reg_wdata_i;
        `FWP_A_DIO_OE: r_next.oen = ~reg_wdata_i;
        default: ;
      endcase
    end
    // Configuration sequencer: block, then load the named path
    case (r_reg.cst)
      CS_IDLE: ;
      CS_BUSY: begin
        if (r_reg.cnt == 6'h00) begin
          r_next.cst = CS_APPLY;
        end else begin
          r_next.cnt = r_reg.cnt - 6'h01;
        end
      end
      CS_APPLY: begin
        r_next.par[r_reg.pend_path] = r_reg.pend;
        r_next.cst = CS_IDLE;
      end
      default: r_next.cst = CS_IDLE;
    endcase
    r_next.busy = (r_next.cst != CS_IDLE);
    // Register reads, data valid in the next cycle only
    if (reg_rd_i) begin
      case (reg_addr_i)
        `FWP_A_CFG: begin
          r_next.rdata[`FWP_SH_LSB +: 4] = r_reg.pend.shift;
          r_next.rdata[`FWP_LEN_LSB +: 5] = r_reg.pend.length;
          r_next.rdata[`FWP_OFS_LSB +: 10] = r_reg.pend.offset;
          r_next.rdata[`FWP_PATH_LSB] = r_reg.pend_path;
        end
        `FWP_A_DIO_CFG: begin
          r_next.rdata[`FWP_VIDX_LSB +: 5] = r_reg.vidx;
          r_next.rdata[`FWP_VPOL_BIT] = r_reg.vpol;
          r_next.rdata[`FWP_DSH_LSB +: 5] = r_reg.dsh;
        end
        `FWP_A_DIO_MASK: r_next.rdata = r_reg.dmask;
        `FWP_A_STATUS: begin
          r_next.rdata[0] = r_reg.busy;
          r_next.rdata[1] = r_reg.par[0].done;
          r_next.rdata[2] = r_reg.par[1].done;
          r_next.rdata[`FWP_ST_WORD_LSB +: 16] = r_reg.word;
        end
        `FWP_A_DIO_OUT: r_next.rdata = r_reg.dout;
        `FWP_A_DIO_OE: r_next.rdata = ~r_reg.oen;
        `FWP_A_LAST_IDX: r_next.rdata[9:0] = r_reg.last_idx;
        default: ;
      endcase
    end
    // Feedback reads from the link, current parameters only
    if (fb_req_i) begin
      r_next.ack = 1'b1;
      if (is_proc(fb_src_i)) begin
        r_next.fbd = res[path_b(fb_src_i)];
      end else begin
        r_next.fbd = {1'b0, r_reg.word};
      end
      if (fb_exec_i) begin
        r_next.ent = 1'b1;
        r_next.idx = is_proc(fb_src_i) ? pidx[path_b(fb_src_i)] : r_reg.word[9:0];
      end
    end
    // Parallel trigger wait: rising edge of the qualified valid
    if (r_reg.wait_arm && qual && !r_reg.vld_d) begin
      r_next.wait_arm = 1'b0;
      r_next.trig = 1'b1;
    end
    if (par_wait_i) begin
      r_next.wait_arm = 1'b1;
    end
    // Parallel play waits for valid; a link execute takes the slot first
    if (r_reg.play_pend && qual && !(fb_req_i && fb_exec_i)) begin
      r_next.play_pend = 1'b0;
      r_next.ent = 1'b1;
      r_next.idx = dio_idx;
    end
    if (par_play_i) begin
      r_next.play_pend = 1'b1;
    end
    if (r_next.ent) begin
      r_next.last_idx = r_next.idx;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      r_reg <= '0;
      r_reg.oen <= `FWP_OEN_RST;
      r_reg.vpol <= `FWP_VPOL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from state
  assign reg_rdata_o = r_reg.rdata;
  assign dio_out_o = r_reg.dout;
  assign dio_oe_n_o = r_reg.oen;
  assign fb_ack_o = r_reg.ack;
  assign fb_data_o = r_reg.fbd;
  assign par_trig_o = r_reg.trig;
  assign ent_stb_o = r_reg.ent;
  assign ent_idx_o = r_reg.idx;
  assign cfg_busy_o = r_reg.busy;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Accepted configuration command and its blocking window
  sequence s_cfg_start;
    reg_wr_i && reg_addr_i == `FWP_A_CFG && r_reg.cst == CS_IDLE && cmd_ok;
  endsequence

  sequence s_cfg_block;
    cfg_busy_o [*8] ##41 cfg_busy_o ##1 !cfg_busy_o;
  endsequence

  raw_pass_a: assert property (
    fb_req_i && fb_src_i == SRC_RAW |=> fb_ack_o && fb_data_o == {1'b0, $past(r_reg.word)})
    else $error("raw source altered the word");

  proc_calc_a: assert property (
    fb_req_i && fb_src_i == SRC_A && r_reg.par[0].done |=>
      fb_data_o == 17'(($past(r_reg.word) >> $past(r_reg.par[0].shift))
                       & ~(16'hffff << $past(r_reg.par[0].length)))
                   + 17'($past(r_reg.par[0].offset)))
    else $error("path A result wrong");

  len_range_a: assert property (
    r_reg.par[1].done |-> r_reg.par[1].length inside {[1:16]})
    else $error("path B length out of range");

  idx_cap_a: assert property (
    fb_req_i && fb_exec_i && fb_src_i == SRC_B && r_reg.par[1].done
      && r_reg.par[1].length > 5'd10 |=>
      ent_stb_o && ent_idx_o == 10'(($past(r_reg.word) >> $past(r_reg.par[1].shift))
                                    + 16'($past(r_reg.par[1].offset))))
    else $error("table index not limited to ten bits");

  cfg_block_a: assert property (
    s_cfg_start |=> s_cfg_block)
    else $error("configuration blocking time wrong");

  par_hold_a: assert property (
    r_reg.cst == CS_BUSY |=> $stable(r_reg.par))
    else $error("parameters changed before completion");

  unconf_raw_a: assert property (
    fb_req_i && fb_src_i == SRC_A && !r_reg.par[0].done |=>
      fb_data_o == {1'b0, $past(r_reg.word)})
    else $error("unconfigured path not transparent");

  alias_dec_a: assert property (
    (s_cfg_start and (cmd_src == SRC_LEG_DEC)) |=> r_reg.pend_path)
    else $error("legacy decoder selector not aimed at path B");

  path_indep_a: assert property (
    r_reg.cst == CS_APPLY && r_reg.pend_path |=> $stable(r_reg.par[0]))
    else $error("loading path B disturbed path A");

  dio_gate_a: assert property (
    r_reg.play_pend && !qual && !(fb_req_i && fb_exec_i) |=> !ent_stb_o)
    else $error("parallel word used while not valid");

  dio_index_a: assert property (
    r_reg.play_pend && qual && !(fb_req_i && fb_exec_i) |=>
      ent_stb_o && ent_idx_o == 10'(($past(r_reg.dio2) >> $past(r_reg.dsh))
                                    & $past(r_reg.dmask)))
    else $error("parallel index wrong");

endmodule : fwp_top
`default_nettype wire

// *** rtl/fwp_map.svh ***
// Register offsets, field positions, reset values and counts of the
// feedback word processor.
// Assumes a byte-addressed 8-bit register port with 32-bit words.
`ifndef FWP_MAP_SVH
`define FWP_MAP_SVH

// Register byte offsets
`define FWP_A_CFG 8'h00
`define FWP_A_DIO_CFG 8'h04
`define FWP_A_DIO_MASK 8'h08
`define FWP_A_STATUS 8'h0c
`define FWP_A_DIO_OUT 8'h10
`define FWP_A_DIO_OE 8'h14
`define FWP_A_LAST_IDX 8'h18

// Configuration command fields
`define FWP_SH_LSB 0
`define FWP_LEN_LSB 4
`define FWP_OFS_LSB 9
`define FWP_PATH_LSB 20

// Parallel port configuration fields
`define FWP_VIDX_LSB 0
`define FWP_VPOL_BIT 5
`define FWP_DSH_LSB 6

// Status fields
`define FWP_ST_WORD_LSB 16

// Length limits of the processed paths
`define FWP_LEN_MIN 5'd1
`define FWP_LEN_MAX 5'd16
`define FWP_IDX_BITS 5'd10

// Clock cycles a configuration command spends in CS_BUSY; blocking lasts one more for CS_APPLY
`define FWP_CFG_CYC 6'd48

// Reset values
`define FWP_OEN_RST 32'hffffffff
`define FWP_VPOL_RST 1'b1

`endif

// *** rtl/fwp_pkg.sv ***
// Types of the feedback word processor.
// Assumes fwp_map.svh for all offsets and counts.
package fwp_pkg;

  // Feedback source selectors
  typedef enum logic [2:0] {
    SRC_RAW = 3'h0,
    SRC_A = 3'h1,
    SRC_B = 3'h2,
    SRC_LEG_REG = 3'h3,
    SRC_LEG_DEC = 3'h4
  } fwp_src_t;

  // Configuration sequencer states, Gray from CS_IDLE to CS_APPLY, both bits flip on the return to CS_IDLE
  typedef enum logic [1:0] {
    CS_IDLE = 2'h0,
    CS_BUSY = 2'h1,
    CS_APPLY = 2'h3
  } fwp_cfg_st_t;

  // Parameter set of one processed path
  typedef struct packed {
    logic [3:0] shift;
    logic [4:0] length;
    logic [9:0] offset;
    logic done;
  } fwp_par_t;

endpackage : fwp_pkg

// *** rtl/fwp_path_if.sv ***
// Carrier between the control logic and one processed path.
// Assumes fwp_pkg is compiled first.
`timescale 1ns/100ps
`default_nettype none
interface fwp_path_if;
  import fwp_pkg::*;
  fwp_par_t par;
  logic [15:0] word;
  logic [16:0] result;
  logic [9:0] index;
  modport ctrl(output par, output word, input result, input index);
  modport proc(input par, input word, output result, output index);
endinterface : fwp_path_if
`default_nettype wire

// *** rtl/fwp_proc.sv ***
// One processed feedback path: shift, length mask and offset.
// Assumes held word and parameters come from registers of the caller.
`timescale 1ns/100ps
`default_nettype none
`include "fwp_map.svh"
module fwp_proc (
  fwp_path_if.proc p
);
  import fwp_pkg::*;

  logic [15:0] shifted;
  logic [15:0] mask;
  logic [15:0] imask;
  logic [4:0] ilen;

  // Mask of 2**length-1 and a table index limited to ten bits
  always_comb begin
    shifted = p.word >> p.par.shift;
    mask = 16'hffff >> (`FWP_LEN_MAX - p.par.length);
    ilen = (p.par.length > `FWP_IDX_BITS) ? `FWP_IDX_BITS : p.par.length;
    imask = 16'hffff >> (`FWP_LEN_MAX - ilen);
  end

  // Unconfigured path passes the word as is
  assign p.result = p.par.done ? (17'(shifted & mask) + 17'(p.par.offset))
                               : {1'b0, p.word};
  assign p.index = p.par.done ? 10'((shifted & imask) + 16'(p.par.offset))
                              : p.word[9:0];

endmodule : fwp_proc
`default_nettype wire

// *** sim/fwp_far_model.sv ***
// Far-side model: feedback controller on the link and the parallel port.
// Assumes the device samples both through its own synchronisers.
`timescale 1ns/100ps
`default_nettype none
module fwp_far_model (
  input wire logic clk_i,
  output logic [15:0] link_word_o,
  output logic link_stb_o,
  output logic [31:0] dio_o
);
  // Idle levels at time zero
  initial begin
    link_word_o = 16'h0;
    link_stb_o = 1'b0;
    dio_o = 32'h0;
  end

  // One message: word settles, strobe 4 cycles, word scrambled once hold ends
  task automatic send_link(input logic [15:0] w);
    @(posedge clk_i);
    link_word_o <= w;
    @(posedge clk_i);
    link_stb_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    link_stb_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    link_word_o <= ~w;
    repeat (3) @(posedge clk_i);
  endtask : send_link

  // One frame: data stable over the whole valid window, scrambled after it
  task automatic dio_frame(input logic [31:0] d, input logic [4:0] vi, input logic pol);
    logic [31:0] v;
    v = d;
    v[vi] = ~pol;
    @(posedge clk_i);
    dio_o <= v;
    repeat (3) @(posedge clk_i);
    v[vi] = pol;
    dio_o <= v;
    repeat (8) @(posedge clk_i);
    v = ~d;
    v[vi] = ~pol;
    dio_o <= v;
  endtask : dio_frame
endmodule : fwp_far_model
`default_nettype wire

// *** sim/fwp_top_tb_top.sv ***
// Self-checking bench of the feedback word processor.
// Assumes the far-side model drives link and parallel pins.
`timescale 1ns/100ps
`default_nettype none
`include "fwp_map.svh"
module fwp_top_tb_top;
  import fwp_pkg::*;
  typedef struct {
    fwp_src_t s;
    logic [3:0] sh;
    logic [4:0] len;
    logic [9:0] ofs;
    logic [15:0] w;
    logic [16:0] d;
    logic [9:0] x;
  } fwp_row_t;
  fwp_row_t rows [4] = '{
    '{SRC_A, 4'h4, 5'h03, 10'h005, 16'hbeef, 17'h0000b, 10'h00b},
    '{SRC_B, 4'h0, 5'h10, 10'h3ff, 16'hffff, 17'h103fe, 10'h3fe},
    '{SRC_LEG_REG, 4'hf, 5'h01, 10'h000, 16'h8000, 17'h00001, 10'h001},
    '{SRC_LEG_DEC, 4'h2, 5'h0c, 10'h010, 16'h1234, 17'h0049d, 10'h09d}};
  logic clk, resetn, reg_wr, reg_rd, lstb, fb_req, fb_exec, par_wait, par_play;
  logic ack, trig, ent_stb, busy;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, dio, dio_out, dio_oe_n;
  logic [15:0] lword;
  logic [16:0] fb_data;
  logic [9:0] ent_idx, si;
  fwp_src_t src;
  int error_cnt, total_checks, n, tn, sn;

  fwp_top i_fwp_top (.ref_clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
    .link_word_i(lword), .link_stb_i(lstb), .dio_in_i(dio), .dio_out_o(dio_out),
    .dio_oe_n_o(dio_oe_n), .fb_req_i(fb_req), .fb_src_i(src), .fb_exec_i(fb_exec),
    .fb_ack_o(ack), .fb_data_o(fb_data), .par_wait_i(par_wait), .par_trig_o(trig),
    .par_play_i(par_play), .ent_stb_o(ent_stb), .ent_idx_o(ent_idx), .cfg_busy_o(busy));
  fwp_far_model i_fwp_far_model (.clk_i(clk), .link_word_o(lword), .link_stb_o(lstb),
    .dio_o(dio));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask : rd

  // Bounded wait for the end of a configuration command
  task automatic wait_idle();
    n = 0;
    #1;
    while (busy === 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 60) begin
      chk("busy_timeout", 32'd0, 32'd1);
      print_verdict();
    end
  endtask : wait_idle

  function automatic logic [31:0] cw(fwp_src_t s, logic [3:0] sh, logic [4:0] ln,
                                     logic [9:0] of);
    return 32'(sh) << `FWP_SH_LSB | 32'(ln) << `FWP_LEN_LSB | 32'(of) << `FWP_OFS_LSB |
           32'(s) << `FWP_PATH_LSB;
  endfunction : cw

  task automatic fb(input fwp_src_t s, input logic ex, input logic [16:0] d,
                    input logic [9:0] x);
    @(posedge clk);
    fb_req <= 1'b1;
    src <= s;
    fb_exec <= ex;
    @(posedge clk);
    fb_req <= 1'b0;
    fb_exec <= 1'b0;
    #1;
    chk("ack", 32'd1, 32'(ack));
    chk("fb_data", 32'(d), 32'(fb_data));
    if (ex) begin
      chk("ent_stb", 32'd1, 32'(ent_stb));
      chk("ent_idx", 32'(x), 32'(ent_idx));
    end
  endtask : fb

  // Main sequence
  initial begin
    {resetn, reg_wr, reg_rd, fb_req, fb_exec, par_wait, par_play} = 7'h0;
    addr = 8'h0;
    wdata = 32'h0;
    src = SRC_RAW;
    error_cnt = 0;
    total_checks = 0;
    repeat (11) @(posedge clk);
    #1;
    chk("oe_n_rst", `FWP_OEN_RST, dio_oe_n);
    chk("out_rst", 32'h0, dio_out);
    @(posedge clk);
    resetn <= 1'b1;
    rd(`FWP_A_DIO_CFG, 32'h20);
    rd(`FWP_A_DIO_OE, 32'h0);
    rd(8'h1c, 32'h0);
    wr(`FWP_A_DIO_OUT, 32'h5a5a0f0f);
    wr(`FWP_A_DIO_OE, 32'h0000ffff);
    rd(`FWP_A_DIO_OE, 32'h0000ffff);
    chk("dio_out", 32'h5a5a0f0f, dio_out);
    chk("dio_oe_n", 32'hffff0000, dio_oe_n);
    i_fwp_far_model.send_link(16'ha5c3);
    rd(`FWP_A_STATUS, 32'ha5c30000);
    fb(SRC_A, 1'b1, 17'h0a5c3, 10'h1c3);
    fb(SRC_B, 1'b0, 17'h0a5c3, 10'h0);
    foreach (rows[i]) begin
      i_fwp_far_model.send_link(rows[i].w);
      wr(`FWP_A_CFG, cw(rows[i].s, rows[i].sh, rows[i].len, rows[i].ofs));
      wait_idle();
      chk("busy_cycles", 32'd49, n);
      fb(rows[i].s, 1'b1, rows[i].d, rows[i].x);
    end
    fb(SRC_RAW, 1'b0, 17'h01234, 10'h0);
    fb(SRC_A, 1'b1, 17'h0, 10'h0);
    wr(`FWP_A_CFG, cw(SRC_A, 4'h0, 5'h10, 10'h0));
    fb(SRC_A, 1'b0, 17'h0, 10'h0);
    wr(`FWP_A_CFG, cw(SRC_B, 4'h0, 5'h10, 10'h1));
    wait_idle();
    fb(SRC_A, 1'b0, 17'h01234, 10'h0);
    fb(SRC_B, 1'b1, 17'h0049d, 10'h09d);
    wr(`FWP_A_CFG, cw(SRC_A, 4'h0, 5'h00, 10'h0));
    @(posedge clk);
    #1;
    chk("busy_bad_len", 32'd0, 32'(busy));
    rd(`FWP_A_STATUS, 32'h12340006);
    wr(`FWP_A_DIO_MASK, 32'h3);
    for (int p = 0; p < 2; p++) begin
      wr(`FWP_A_DIO_CFG, p ? 32'he0 : 32'hdf);
      tn = 0;
      sn = 0;
      si = 10'h0;
      fork
        i_fwp_far_model.dio_frame(p ? 32'h18 : 32'h10, p ? 5'd0 : 5'd31, p[0]);
        begin
          repeat (3) @(posedge clk);
          par_wait <= 1'b1;
          par_play <= 1'b1;
          @(posedge clk);
          par_wait <= 1'b0;
          par_play <= 1'b0;
          repeat (20) begin
            @(posedge clk);
            #1;
            if (trig === 1'b1) tn++;
            if (ent_stb === 1'b1) begin
              sn++;
              si = ent_idx;
            end
          end
        end
      join
      chk("par_trig", 32'd1, tn);
      chk("par_stb", 32'd1, sn);
      chk("par_idx", p ? 32'h3 : 32'h2, 32'(si));
    end
    rd(`FWP_A_LAST_IDX, 32'h3);
    // Mid-run reset clears parameters, held word and port setup
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("ack_rst", 32'd0, 32'(ack));
    chk("data_rst", 32'd0, 32'(fb_data));
    chk("idx_rst", 32'd0, 32'(ent_idx));
    chk("oe_n_rst2", `FWP_OEN_RST, dio_oe_n);
    @(posedge clk);
    resetn <= 1'b1;
    rd(`FWP_A_STATUS, 32'h0);
    fb(SRC_B, 1'b1, 17'h0, 10'h0);
    print_verdict();
  end
endmodule : fwp_top_tb_top
`default_nettype wire
